// ---- rtl/cdr_pkg.sv ----
package cdr_pkg;

  // --------------------------------------------------------------------
  // Register map (printed offsets are indexes, byte address = 4 * index)
  // --------------------------------------------------------------------
  localparam int         ADDR_W            = 8;
  localparam int         REG_INDEX_PIN_CFG = 1;
  localparam int         REG_INDEX_RX_CTL  = 2;
  localparam int         REG_INDEX_TX_CTL  = 3;
  localparam int         REG_INDEX_SQ_CTL  = 4;
  localparam int         REG_INDEX_IRQ_ST  = 8;
  localparam int         REG_INDEX_IRQ_MSK = 9;
  localparam logic [7:0] ADDR_PIN_CFG      = 8'(4 * REG_INDEX_PIN_CFG);
  localparam logic [7:0] ADDR_RX_CTL       = 8'(4 * REG_INDEX_RX_CTL);
  localparam logic [7:0] ADDR_TX_CTL       = 8'(4 * REG_INDEX_TX_CTL);
  localparam logic [7:0] ADDR_SQ_CTL       = 8'(4 * REG_INDEX_SQ_CTL);
  localparam logic [7:0] ADDR_IRQ_ST       = 8'(4 * REG_INDEX_IRQ_ST);
  localparam logic [7:0] ADDR_IRQ_MSK      = 8'(4 * REG_INDEX_IRQ_MSK);

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int POL_BIT     = 4;
  localparam int ROLE_BIT    = 2;
  localparam int FORCE_N_BIT = 3;
  localparam int LOCK_BIT    = 0;
  localparam int SQUELCH_LEVEL_SELECT_BIT  = 7;
  localparam int SQ_EN_BIT   = 6;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] PIN_CFG_RST = 8'h17;
  localparam logic [7:0] RX_CTL_RST  = 8'h18;
  localparam logic [7:0] TX_CTL_RST  = 8'h18;
  localparam logic [7:0] SQ_CTL_RST  = 8'h7b;

  // --------------------------------------------------------------------
  // Interrupt bits
  // --------------------------------------------------------------------
  localparam int         IRQ_W           = 4;
  localparam int         IRQ_TX_LOCK     = 0;
  localparam int         IRQ_RX_LOCK     = 1;
  localparam int         IRQ_LOS         = 2;
  localparam int         IRQ_DETECT_LOST = 3;
  localparam logic [3:0] IRQ_RST         = 4'h0;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PLL_REF,
    PLL_DATA,
    PLL_LOCKED
  } cdr_pll_state_t;

  typedef struct packed {
    logic tx_ref_lock;
    logic tx_data_lock;
    logic rx_ref_lock;
    logic rx_data_lock;
    logic signal_sensed;
    logic detect_pin;
  } cdr_sense_t;

  localparam int SENSE_W = $bits(cdr_sense_t);

  typedef struct packed {
    logic [7:0]     pin_cfg;
    logic [7:0]     rx_ctl;
    logic [7:0]     tx_ctl;
    logic [7:0]     sq_ctl;
    logic [3:0]     irq_status;
    logic [3:0]     irq_mask;
    cdr_pll_state_t tx_pll;
    cdr_pll_state_t rx_pll;
    logic           tx_lock;
    logic           rx_lock;
    logic           los_seen;
    logic           detect_seen;
    logic           dp_write;
    logic [7:0]     dp_addr;
    logic [31:0]    rdata;
  } cdr_state_t;

endpackage

// ---- rtl/cdr_sync.sv ----
`timescale 1ns/1ps
module cdr_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } cdr_sync_state_t;

  cdr_sync_state_t st_reg;
  cdr_sync_state_t st_next;

  // --------------------------------------------------------------------
  // Three stages, a change counts once stages two and three agree
  // --------------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(sync_out) |-> $past(st_reg.s2 == st_reg.s3))
    else $error("Synchroniser output changed without stage agreement");

endmodule

// ---- rtl/cdr_lock_detect.sv ----
`timescale 1ns/1ps
// What this block does
// - Transmit lock rises only after reference lock, then data lock.
// - Transmit lock leaves as a plain level; users must resynchronise it.
// - Receive lock rises only after reference lock, then data lock.
// - Receive lock leaves as a plain level with no clock relation.
// - In output role the status pin goes high on loss of signal.
// - Loss-of-signal pin level follows the sense input without registering.
// - Role bit at zero releases the status pin, which becomes detect input.
// - Detect input active high by default, polarity bit at zero selects active low.
// - Detect inactive forces the receive PLL onto the reference clock.
// - Detect inactive with squelch enabled holds receive output at chosen level.
// - Role bit is bit 2 of index 0x01, reset to loss-of-signal output.
// - Detect polarity is bit 4 of index 0x01, reset to active high.
// - Squelch level bit 7, enable bit 6 of index 0x04; low, enabled.
module cdr_lock_detect (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  // PLL status from the analog side
  input  wire logic        tx_ref_locked,
  input  wire logic        tx_data_locked,
  input  wire logic        rx_ref_locked,
  input  wire logic        rx_data_locked,
  input  wire logic        rx_signal_sensed,
  output logic             tx_pll_ref_select,
  output logic             rx_pll_ref_select,
  // Receive data path
  input  wire logic        rx_recovered_data,
  output logic             receive_serial_output,
  // Pins
  output logic             transmit_lock_indicator,
  output logic             receive_lock_indicator,
  input  wire logic        dual_signal_status_pin_in,
  output logic             dual_signal_status_pin_out,
  output logic             dual_signal_status_pin_oe
);

  cdr_pkg::cdr_state_t st_reg;
  cdr_pkg::cdr_state_t st_next;
  cdr_pkg::cdr_sense_t sense_raw;
  cdr_pkg::cdr_sense_t sense;

  logic       detect_active;
  logic       detect_inactive;
  logic       rx_force_ref;
  logic       tx_force_ref;
  logic       squelch_active;
  logic       los_now;
  logic       addr_take;
  logic [3:0] irq_events;
  logic [3:0] irq_clear;
  logic [7:0] rd_byte;

  // --------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------
  assign sense_raw.tx_ref_lock   = tx_ref_locked;
  assign sense_raw.tx_data_lock  = tx_data_locked;
  assign sense_raw.rx_ref_lock   = rx_ref_locked;
  assign sense_raw.rx_data_lock  = rx_data_locked;
  assign sense_raw.signal_sensed = rx_signal_sensed;
  assign sense_raw.detect_pin    = dual_signal_status_pin_in;

  cdr_sync #(
    .WIDTH (cdr_pkg::SENSE_W)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (sense_raw),
    .sync_out (sense)
  );

  // --------------------------------------------------------------------
  // Acquisition step, shared by both PLLs
  // --------------------------------------------------------------------
  function automatic cdr_pkg::cdr_pll_state_t pll_step(
    input cdr_pkg::cdr_pll_state_t cur,
    input logic                    ref_lock,
    input logic                    data_lock,
    input logic                    force_ref
  );
    cdr_pkg::cdr_pll_state_t nxt;
    nxt = cur;
    case (cur)
      cdr_pkg::PLL_REF: begin
        if (!force_ref && ref_lock) begin
          nxt = cdr_pkg::PLL_DATA;
        end
      end
      cdr_pkg::PLL_DATA: begin
        if (force_ref) begin
          nxt = cdr_pkg::PLL_REF;
        end else if (data_lock) begin
          nxt = cdr_pkg::PLL_LOCKED;
        end
      end
      cdr_pkg::PLL_LOCKED: begin
        if (force_ref || !data_lock) begin
          nxt = cdr_pkg::PLL_REF;
        end
      end
      default: begin
        nxt = cdr_pkg::PLL_REF;
      end
    endcase
    return nxt;
  endfunction

  // --------------------------------------------------------------------
  // Register read data
  // --------------------------------------------------------------------
  function automatic logic [7:0] read_mux(
    input cdr_pkg::cdr_state_t s,
    input logic [7:0]          addr
  );
    logic [7:0] v;
    v = 8'h00;
    if (addr == cdr_pkg::ADDR_PIN_CFG) begin
      v = s.pin_cfg;
    end else if (addr == cdr_pkg::ADDR_RX_CTL) begin
      v = s.rx_ctl;
      v[cdr_pkg::LOCK_BIT] = s.rx_lock;
    end else if (addr == cdr_pkg::ADDR_TX_CTL) begin
      v = s.tx_ctl;
      v[cdr_pkg::LOCK_BIT] = s.tx_lock;
    end else if (addr == cdr_pkg::ADDR_SQ_CTL) begin
      v = s.sq_ctl;
    end else if (addr == cdr_pkg::ADDR_IRQ_ST) begin
      v = {4'h0, s.irq_status};
    end else if (addr == cdr_pkg::ADDR_IRQ_MSK) begin
      v = {4'h0, s.irq_mask};
    end
    return v;
  endfunction

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    detect_active   = st_reg.pin_cfg[cdr_pkg::POL_BIT] ?
                      sense.detect_pin : ~sense.detect_pin;
    // Detect only steers anything while the pin is an input
    detect_inactive = ~st_reg.pin_cfg[cdr_pkg::ROLE_BIT] & ~detect_active;
    rx_force_ref    = detect_inactive | ~st_reg.rx_ctl[cdr_pkg::FORCE_N_BIT];
    tx_force_ref    = ~st_reg.tx_ctl[cdr_pkg::FORCE_N_BIT];
    los_now         = st_reg.pin_cfg[cdr_pkg::ROLE_BIT] & ~sense.signal_sensed;

    st_next.tx_pll  = pll_step(st_reg.tx_pll, sense.tx_ref_lock,
                               sense.tx_data_lock, tx_force_ref);
    st_next.rx_pll  = pll_step(st_reg.rx_pll, sense.rx_ref_lock,
                               sense.rx_data_lock, rx_force_ref);
    st_next.tx_lock = (st_next.tx_pll == cdr_pkg::PLL_LOCKED);
    st_next.rx_lock = (st_next.rx_pll == cdr_pkg::PLL_LOCKED);
    st_next.los_seen    = los_now;
    st_next.detect_seen = detect_inactive;

    irq_events = 4'h0;
    irq_events[cdr_pkg::IRQ_TX_LOCK]     = st_next.tx_lock ^ st_reg.tx_lock;
    irq_events[cdr_pkg::IRQ_RX_LOCK]     = st_next.rx_lock ^ st_reg.rx_lock;
    irq_events[cdr_pkg::IRQ_LOS]         = los_now & ~st_reg.los_seen;
    irq_events[cdr_pkg::IRQ_DETECT_LOST] = detect_inactive & ~st_reg.detect_seen;

    // Data phase write; reserved bits are kept as written, except mask bits 7:4, which are dropped
    if (st_reg.dp_write) begin
      if (st_reg.dp_addr == cdr_pkg::ADDR_PIN_CFG) begin
        st_next.pin_cfg = hwdata[7:0];
      end else if (st_reg.dp_addr == cdr_pkg::ADDR_RX_CTL) begin
        st_next.rx_ctl = hwdata[7:0];
      end else if (st_reg.dp_addr == cdr_pkg::ADDR_TX_CTL) begin
        st_next.tx_ctl = hwdata[7:0];
      end else if (st_reg.dp_addr == cdr_pkg::ADDR_SQ_CTL) begin
        st_next.sq_ctl = hwdata[7:0];
      end else if (st_reg.dp_addr == cdr_pkg::ADDR_IRQ_MSK) begin
        st_next.irq_mask = hwdata[3:0];
      end
    end

    // Address phase: read data is prepared now so it leaves a flop
    addr_take        = hsel & hready & htrans[1];
    irq_clear        = 4'h0;
    st_next.dp_write = addr_take & hwrite;
    st_next.dp_addr  = haddr[7:0];
    rd_byte          = read_mux(st_reg, haddr[7:0]);
    if (addr_take && !hwrite) begin
      st_next.rdata = {24'h000000, rd_byte};
      if (haddr[7:0] == cdr_pkg::ADDR_IRQ_ST) begin
        irq_clear = 4'hf;
      end
    end
    // A new event beats a clearing read in the same cycle
    st_next.irq_status = (st_reg.irq_status & ~irq_clear) | irq_events;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg             <= '0;
      st_reg.pin_cfg     <= cdr_pkg::PIN_CFG_RST;
      st_reg.rx_ctl      <= cdr_pkg::RX_CTL_RST;
      st_reg.tx_ctl      <= cdr_pkg::TX_CTL_RST;
      st_reg.sq_ctl      <= cdr_pkg::SQ_CTL_RST;
      st_reg.irq_status  <= cdr_pkg::IRQ_RST;
      st_reg.irq_mask    <= cdr_pkg::IRQ_RST;
      st_reg.tx_pll      <= cdr_pkg::PLL_REF;
      st_reg.rx_pll      <= cdr_pkg::PLL_REF;
      // Loss presumed until the synchroniser fills, so reset raises no false event
      st_reg.los_seen    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(st_reg.irq_status & st_reg.irq_mask);

  assign tx_pll_ref_select = (st_reg.tx_pll == cdr_pkg::PLL_REF);
  assign rx_pll_ref_select = (st_reg.rx_pll == cdr_pkg::PLL_REF);

  // Lock levels come from flops but carry no timing promise to the pad
  assign transmit_lock_indicator = st_reg.tx_lock;
  assign receive_lock_indicator  = st_reg.rx_lock;

  // Squelch holds the level statically; the data path itself is not retimed here
  assign squelch_active        = detect_inactive & st_reg.sq_ctl[cdr_pkg::SQ_EN_BIT];
  assign receive_serial_output = squelch_active ?
                                 st_reg.sq_ctl[cdr_pkg::SQUELCH_LEVEL_SELECT_BIT] :
                                 rx_recovered_data;

  // Raw sense drives the pad so loss shows with no clock latency
  assign dual_signal_status_pin_out = ~rx_signal_sensed;
  assign dual_signal_status_pin_oe  = st_reg.pin_cfg[cdr_pkg::ROLE_BIT];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_TX_LOCK_AFTER_DATA: assert property (
    $rose(transmit_lock_indicator) |->
      $past(st_reg.tx_pll) == cdr_pkg::PLL_DATA && $past(sense.tx_data_lock))
    else $error("Transmit lock rose without data lock phase");

  AST_TX_DATA_AFTER_REF: assert property (
    $rose(st_reg.tx_pll == cdr_pkg::PLL_DATA) |->
      $past(st_reg.tx_pll) == cdr_pkg::PLL_REF && $past(sense.tx_ref_lock))
    else $error("Transmit PLL left reference phase without reference lock");

  AST_RX_LOCK_AFTER_DATA: assert property (
    $rose(receive_lock_indicator) |->
      $past(st_reg.rx_pll) == cdr_pkg::PLL_DATA && $past(sense.rx_data_lock))
    else $error("Receive lock rose without data lock phase");

  AST_LOS_PIN: assert property (
    st_reg.pin_cfg[cdr_pkg::ROLE_BIT] && !rx_signal_sensed |->
      dual_signal_status_pin_oe && dual_signal_status_pin_out)
    else $error("Loss of signal not shown on status pin");

  AST_PIN_RELEASED: assert property (
    st_reg.dp_write && st_reg.dp_addr == cdr_pkg::ADDR_PIN_CFG &&
      !hwdata[cdr_pkg::ROLE_BIT] |=> !dual_signal_status_pin_oe)
    else $error("Status pin still driven in detect role");

  AST_FORCE_REF: assert property (
    !st_reg.pin_cfg[cdr_pkg::ROLE_BIT] &&
      (sense.detect_pin != st_reg.pin_cfg[cdr_pkg::POL_BIT]) |=>
      rx_pll_ref_select && !receive_lock_indicator)
    else $error("Receive PLL not forced to reference while detect inactive");

  AST_SQUELCH_LEVEL: assert property (
    !st_reg.pin_cfg[cdr_pkg::ROLE_BIT] && st_reg.sq_ctl[cdr_pkg::SQ_EN_BIT] &&
      (sense.detect_pin != st_reg.pin_cfg[cdr_pkg::POL_BIT]) |->
      receive_serial_output == st_reg.sq_ctl[cdr_pkg::SQUELCH_LEVEL_SELECT_BIT])
    else $error("Receive output not squelched to selected level");

  AST_LOCK_DROP: assert property (
    st_reg.rx_pll == cdr_pkg::PLL_LOCKED && !sense.rx_data_lock |=>
      !receive_lock_indicator)
    else $error("Receive lock held after data lock was lost");

  AST_LOCK_EVENT_STICKY: assert property (
    $changed(transmit_lock_indicator) &&
      !(hsel && hready && htrans[1] && !hwrite && haddr[7:0] == cdr_pkg::ADDR_IRQ_ST) |->
      st_reg.irq_status[cdr_pkg::IRQ_TX_LOCK] [*2])
    else $error("Transmit lock change not recorded");

  AST_TX_LOCK_LEVEL: assert property (
    transmit_lock_indicator |-> st_reg.tx_pll == cdr_pkg::PLL_LOCKED)
    else $error("Transmit lock shown outside locked state");

  AST_RX_LOCK_LEVEL: assert property (
    receive_lock_indicator |-> st_reg.rx_pll == cdr_pkg::PLL_LOCKED)
    else $error("Receive lock shown outside locked state");

  AST_RX_DATA_AFTER_REF: assert property (
    $rose(st_reg.rx_pll == cdr_pkg::PLL_DATA) |->
      $past(st_reg.rx_pll) == cdr_pkg::PLL_REF && $past(sense.rx_ref_lock))
    else $error("Receive PLL left reference phase without reference lock");

  AST_TX_LOCK_DROP: assert property (
    st_reg.tx_pll == cdr_pkg::PLL_LOCKED && !sense.tx_data_lock |=>
      !transmit_lock_indicator)
    else $error("Transmit lock held after data lock was lost");

  AST_RX_PASS: assert property (
    !(!st_reg.pin_cfg[cdr_pkg::ROLE_BIT] && st_reg.sq_ctl[cdr_pkg::SQ_EN_BIT] &&
      (sense.detect_pin != st_reg.pin_cfg[cdr_pkg::POL_BIT])) |->
      receive_serial_output == rx_recovered_data)
    else $error("Receive output held although squelch is off");

  AST_LOS_EVENT: assert property (
    st_reg.pin_cfg[cdr_pkg::ROLE_BIT] && $fell(sense.signal_sensed) |=>
      st_reg.irq_status[cdr_pkg::IRQ_LOS])
    else $error("Loss of signal not recorded in status");

  COV_TX_LOCK: cover property (
    $rose(transmit_lock_indicator));

  COV_RX_SQUELCH: cover property (
    $rose(squelch_active));

  COV_IRQ: cover property (
    $rose(irq));

  COV_DETECT_ROLE: cover property (
    $fell(dual_signal_status_pin_oe));

endmodule

// ---- sim/cdr_optical_rx_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Optical receiver module on the detect pin
// ----------------------------------------
module cdr_optical_rx_model (
  input  wire logic fitted,
  input  wire logic power_ok,
  input  wire logic active_low,
  output logic      sd_level,
  output logic      sd_oe
);
  // Released pin is left to the board pull-up, never to a stale level
  always_comb begin
    sd_oe    = fitted;
    sd_level = power_ok ^ active_low;
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        tx_ref    = 1'b0;
  logic        tx_dat    = 1'b0;
  logic        rx_ref    = 1'b0;
  logic        rx_dat    = 1'b0;
  logic        sensed    = 1'b1;
  logic        rx_data   = 1'b0;
  logic        fitted    = 1'b0;
  logic        power_ok  = 1'b0;
  logic        act_low   = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        tx_sel;
  logic        rx_sel;
  logic        rx_out;
  logic        tx_lock;
  logic        rx_lock;
  logic        pin_out;
  logic        pin_oe;
  logic        sd_level;
  logic        sd_oe;
  logic        pin;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles    = 0;

  assign hready = hreadyout;
  // Pull-up holds the pin high when nobody drives it
  assign pin = pin_oe ? pin_out : (sd_oe ? sd_level : 1'b1);

  cdr_lock_detect i_dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .tx_ref_locked(tx_ref),
    .tx_data_locked(tx_dat), .rx_ref_locked(rx_ref), .rx_data_locked(rx_dat),
    .rx_signal_sensed(sensed), .tx_pll_ref_select(tx_sel), .rx_pll_ref_select(rx_sel),
    .rx_recovered_data(rx_data), .receive_serial_output(rx_out),
    .transmit_lock_indicator(tx_lock), .receive_lock_indicator(rx_lock),
    .dual_signal_status_pin_in(pin), .dual_signal_status_pin_out(pin_out),
    .dual_signal_status_pin_oe(pin_oe)
  );

  cdr_optical_rx_model i_rx_module (
    .fitted(fitted), .power_ok(power_ok), .active_low(act_low),
    .sd_level(sd_level), .sd_oe(sd_oe)
  );

  always #25 clk = ~clk;

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic pick(input int which);
    case (which)
      0:       return tx_lock;
      1:       return rx_lock;
      2:       return tx_sel;
      3:       return rx_sel;
      default: return irq;
    endcase
  endfunction

  // Samples at falling edges so flop updates have landed
  task automatic wait_bit(input int which, input logic val, input string name);
    int n;
    n = 0;
    @(negedge clk);
    while (pick(which) !== val && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(name, 32'(val), 32'(pick(which)));
  endtask

  task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp okay", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb_xfer(a, 1'b1, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] rd;
    ahb_xfer(a, 1'b0, 32'h0, rd);
    chk(name, exp, rd);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map();
    logic [7:0]  a [8] = '{cdr_pkg::ADDR_PIN_CFG, cdr_pkg::ADDR_RX_CTL, cdr_pkg::ADDR_TX_CTL,
                           cdr_pkg::ADDR_SQ_CTL, cdr_pkg::ADDR_IRQ_ST, cdr_pkg::ADDR_IRQ_MSK,
                           8'h00, 8'h40};
    logic [31:0] e [8] = '{32'h17, 32'h18, 32'h18, 32'h7b, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) begin
      rd_chk(a[i], e[i], "reset value");
    end
    wr(8'h40, 32'hff);
    rd_chk(8'h40, 32'h0, "unmapped read");
    wr(cdr_pkg::ADDR_RX_CTL, 32'h19);
    rd_chk(cdr_pkg::ADDR_RX_CTL, 32'h18, "read-only lock bit");
    chk("pin oe after reset", 32'h1, 32'(pin_oe));
    $display("Test reset_map done");
  endtask

  task automatic t_los();
    wr(cdr_pkg::ADDR_IRQ_MSK, 32'h4);
    @(posedge clk);
    sensed <= 1'b0;
    @(negedge clk);
    chk("loss pin level", 32'h1, 32'(pin));
    wait_bit(4, 1'b1, "loss irq");
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'h4, "loss status");
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'h0, "status cleared");
    chk("irq after clear", 32'h0, 32'(irq));
    @(posedge clk);
    sensed <= 1'b1;
    @(negedge clk);
    chk("signal back pin level", 32'h0, 32'(pin));
    $display("Test los done");
  endtask

  task automatic t_tx_lock();
    wr(cdr_pkg::ADDR_IRQ_MSK, 32'h3);
    @(posedge clk);
    tx_dat <= 1'b1;
    repeat (10) @(negedge clk);
    chk("tx lock without ref", 32'h0, 32'(tx_lock));
    @(posedge clk);
    tx_dat <= 1'b0;
    tx_ref <= 1'b1;
    wait_bit(2, 1'b0, "tx ref select");
    repeat (10) @(negedge clk);
    chk("tx lock before data", 32'h0, 32'(tx_lock));
    @(posedge clk);
    tx_dat <= 1'b1;
    wait_bit(0, 1'b1, "tx lock");
    chk("irq on tx lock", 32'h1, 32'(irq));
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'h1, "tx lock status");
    rd_chk(cdr_pkg::ADDR_TX_CTL, 32'h19, "tx ctl lock bit");
    @(posedge clk);
    tx_dat <= 1'b0;
    wait_bit(0, 1'b0, "tx lock drop");
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'h1, "tx drop status");
    wr(cdr_pkg::ADDR_TX_CTL, 32'h10);
    wait_bit(2, 1'b1, "tx forced ref");
    wr(cdr_pkg::ADDR_TX_CTL, 32'h18);
    @(posedge clk);
    tx_ref <= 1'b0;
    $display("Test tx_lock done");
  endtask

  task automatic t_detect();
    logic [31:0] rd;
    wr(cdr_pkg::ADDR_IRQ_MSK, 32'ha);
    wr(cdr_pkg::ADDR_PIN_CFG, 32'h13);
    @(negedge clk);
    chk("pin released", 32'h0, 32'(pin_oe));
    // Synchroniser still holds the driven level briefly; clear that event
    repeat (6) @(negedge clk);
    ahb_xfer(cdr_pkg::ADDR_IRQ_ST, 1'b0, 32'h0, rd);
    @(posedge clk);
    fitted   <= 1'b1;
    power_ok <= 1'b1;
    rx_ref   <= 1'b1;
    rx_dat   <= 1'b1;
    rx_data  <= 1'b1;
    wait_bit(1, 1'b1, "rx lock");
    chk("rx data passes", 32'h1, 32'(rx_out));
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'h2, "rx lock status");
    @(posedge clk);
    power_ok <= 1'b0;
    wait_bit(1, 1'b0, "rx lock on detect loss");
    chk("rx forced to ref", 32'h1, 32'(rx_sel));
    chk("squelch low", 32'h0, 32'(rx_out));
    rd_chk(cdr_pkg::ADDR_IRQ_ST, 32'ha, "detect loss status");
    wr(cdr_pkg::ADDR_SQ_CTL, 32'hfb);
    @(posedge clk);
    rx_data <= 1'b0;
    @(negedge clk);
    chk("squelch high", 32'h1, 32'(rx_out));
    wr(cdr_pkg::ADDR_SQ_CTL, 32'hbb);
    @(negedge clk);
    chk("squelch disabled", 32'h0, 32'(rx_out));
    wr(cdr_pkg::ADDR_PIN_CFG, 32'h03);
    @(posedge clk);
    act_low  <= 1'b1;
    power_ok <= 1'b1;
    wait_bit(1, 1'b1, "active low detect");
    @(posedge clk);
    rx_dat <= 1'b0;
    wait_bit(1, 1'b0, "rx lock on data loss");
    wr(cdr_pkg::ADDR_PIN_CFG, 32'h17);
    @(negedge clk);
    chk("pin driven again", 32'h1, 32'(pin_oe));
    @(posedge clk);
    fitted <= 1'b0;
    $display("Test detect done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_map();
    t_los();
    t_tx_lock();
    t_detect();
    results();
  end
endmodule
